// [hw/wsc_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module wsc_channel (
    input wire logic ref_clk,
    input wire logic rst_n,
    wsc_chan_if.chan ch
);
    // ****************************************************************
    // sensor input synchroniser
    // ****************************************************************
    logic sens_meta_ff;
    logic sens_sync_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sens_meta_ff <= 1'b0;
            sens_sync_ff <= 1'b0;
        end
        else
        begin
            sens_meta_ff <= ch.sensor_level;
            sens_sync_ff <= sens_meta_ff;
        end
    end

    // ****************************************************************
    // input filter and output stage
    // ****************************************************************
    logic [8:0] filt_cnt_ff;
    logic [8:0] nxt_filt_cnt;
    logic filt_state_ff;
    logic nxt_filt_state;
    logic pulse_ff;
    logic nxt_pulse;
    logic pass_ff;
    logic nxt_pass;
    logic fixed_ff;
    logic three_ff;
    logic pwm_ff;
    logic one_edge_ff;
    logic [8:0] limit;
    logic [1:0] sensor_type;
    logic suppress;

    always_comb
    begin
        sensor_type = ch.cfg[wsc_pkg::TYPE_LSB +: 2];
        limit = wsc_pkg::filt_cycles(ch.cfg[wsc_pkg::FILT_LSB +: 4]); // [R1]
        nxt_filt_cnt = filt_cnt_ff;
        nxt_filt_state = filt_state_ff;
        // level must hold for the whole filter time before it is taken
        if (sens_sync_ff == filt_state_ff)
        begin
            nxt_filt_cnt = '0;
        end
        else if (filt_cnt_ff + 9'h001 >= limit) // [R1]
        begin
            nxt_filt_cnt = '0;
            nxt_filt_state = sens_sync_ff;
        end
        else
        begin
            nxt_filt_cnt = filt_cnt_ff + 9'h001;
        end
        nxt_pass = ch.cfg[wsc_pkg::PASS_BIT] & sensor_type[1]; // [R2]
        suppress = ch.cfg[wsc_pkg::STILL_BIT] & (sensor_type == wsc_pkg::TYPE_PWM_TWO_EDGE)
            & ch.standstill; // [R3]
        nxt_pulse = ch.out_enable & ~suppress
            & (nxt_pass ? sens_sync_ff : filt_state_ff); // [R2] [R3]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_cnt_ff <= '0;
            filt_state_ff <= 1'b0;
            pulse_ff <= 1'b0;
            pass_ff <= 1'b0;
            fixed_ff <= 1'b0;
            three_ff <= 1'b0;
            pwm_ff <= 1'b0;
            one_edge_ff <= 1'b0;
        end
        else
        begin
            filt_cnt_ff <= nxt_filt_cnt;
            filt_state_ff <= nxt_filt_state;
            pulse_ff <= nxt_pulse;
            pass_ff <= nxt_pass;
            fixed_ff <= ch.cfg[wsc_pkg::FIXTH_BIT]; // [R4]
            three_ff <= (sensor_type == wsc_pkg::TYPE_THREE_LEVEL); // [R5]
            pwm_ff <= sensor_type[1]; // [R5]
            one_edge_ff <= (sensor_type == wsc_pkg::TYPE_PWM_ONE_EDGE); // [R5]
        end
    end

    assign ch.speed_pulse = pulse_ff;
    assign ch.pass_active = pass_ff;
    assign ch.fixed_thr = fixed_ff;
    assign ch.three_level = three_ff;
    assign ch.pwm_type = pwm_ff;
    assign ch.one_edge = one_edge_ff;
endmodule // wsc_channel
`default_nettype wire

// [hw/wsc_top.sv]
// Operation
// R1: filter time is 8 us plus filter code times 500 ns.
// R2: pass-through bit set on a PWM sensor type bypasses the filter.
// R3: PWM two-edge channel with standstill bit set mutes output at standstill.
// R4: threshold bit 0 selects adaptive thresholds, 1 selects fixed ones.
// R5: sensor type 00 standard, 01 VDA, 10 PWM two-edge, 11 PWM one-edge.
// R6: undervoltage, ground loss or power-on reset clear every channel field.
// R7: ten-bit fields, upper channel bits 19:10, pair b at offset 0x04.
// R8: software sets config-access enable before writing channel settings.
// R9: fixed mode uses low threshold and low plus offset as second.
// R10: unused bit of each field ignores writes and reads zero.
`timescale 1ns/1ps
`default_nettype none
module wsc_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [19:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [19:0] reg_rdata,
    input wire logic battery_undervoltage_event,
    input wire logic ground_loss_event,
    input wire logic [3:0] sensor_level,
    input wire logic [3:0] standstill_detect,
    output logic [3:0] speed_pulse_output,
    output logic [3:0] pass_through_active,
    output logic [3:0] fixed_threshold_active,
    output logic [3:0] three_level_sensor,
    output logic [3:0] pwm_sensor,
    output logic [3:0] one_edge_per_tooth,
    output logic [7:0] fixed_low_threshold,
    output logic [8:0] fixed_high_threshold
);
    // ****************************************************************
    // supply event synchronisers
    // ****************************************************************
    logic uv_meta_ff;
    logic uv_sync_ff;
    logic gl_meta_ff;
    logic gl_sync_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            uv_meta_ff <= 1'b0;
            uv_sync_ff <= 1'b0;
            gl_meta_ff <= 1'b0;
            gl_sync_ff <= 1'b0;
        end
        else
        begin
            uv_meta_ff <= battery_undervoltage_event;
            uv_sync_ff <= uv_meta_ff;
            gl_meta_ff <= ground_loss_event;
            gl_sync_ff <= gl_meta_ff;
        end
    end

    logic supply_clear;
    assign supply_clear = uv_sync_ff | gl_sync_ff;

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [19:0] cfg_pair_a_ff;
    logic [19:0] nxt_cfg_pair_a;
    logic [19:0] cfg_pair_b_ff;
    logic [19:0] nxt_cfg_pair_b;
    logic [19:0] ctrl_ff;
    logic [19:0] nxt_ctrl;
    logic [19:0] thresh_ff;
    logic [19:0] nxt_thresh;
    logic [19:0] rdata_ff;
    logic [19:0] nxt_rdata;
    logic cfg_access_en;

    always_comb
    begin
        nxt_cfg_pair_a = cfg_pair_a_ff;
        nxt_cfg_pair_b = cfg_pair_b_ff;
        nxt_ctrl = ctrl_ff;
        nxt_thresh = thresh_ff;
        nxt_rdata = 20'h0_0000;
        cfg_access_en = ctrl_ff[wsc_pkg::CTRL_CFG_EN_BIT];
        if (supply_clear)
        begin
            nxt_cfg_pair_a = wsc_pkg::RST_CFG_PAIR; // [R6]
            nxt_cfg_pair_b = wsc_pkg::RST_CFG_PAIR; // [R6]
            nxt_ctrl = wsc_pkg::RST_CTRL;
            nxt_thresh = wsc_pkg::RST_THRESH;
        end
        else if (reg_wr)
        begin
            if (reg_addr == wsc_pkg::OFS_CFG_PAIR_A)
            begin
                if (cfg_access_en) // [R8]
                begin
                    nxt_cfg_pair_a = reg_wdata & wsc_pkg::MASK_CFG_PAIR; // [R10]
                end
            end
            else if (reg_addr == wsc_pkg::OFS_CFG_PAIR_B) // [R7]
            begin
                if (cfg_access_en) // [R8]
                begin
                    nxt_cfg_pair_b = reg_wdata & wsc_pkg::MASK_CFG_PAIR; // [R10]
                end
            end
            else if (reg_addr == wsc_pkg::OFS_CTRL)
            begin
                nxt_ctrl = reg_wdata & wsc_pkg::MASK_CTRL;
            end
            else if (reg_addr == wsc_pkg::OFS_THRESH)
            begin
                nxt_thresh = reg_wdata & wsc_pkg::MASK_THRESH;
            end
        end
        if (reg_rd)
        begin
            if (reg_addr == wsc_pkg::OFS_CFG_PAIR_A)
            begin
                nxt_rdata = cfg_pair_a_ff;
            end
            else if (reg_addr == wsc_pkg::OFS_CFG_PAIR_B)
            begin
                nxt_rdata = cfg_pair_b_ff;
            end
            else if (reg_addr == wsc_pkg::OFS_CTRL)
            begin
                nxt_rdata = ctrl_ff;
            end
            else if (reg_addr == wsc_pkg::OFS_THRESH)
            begin
                nxt_rdata = thresh_ff;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_pair_a_ff <= wsc_pkg::RST_CFG_PAIR; // [R6]
            cfg_pair_b_ff <= wsc_pkg::RST_CFG_PAIR; // [R6]
            ctrl_ff <= wsc_pkg::RST_CTRL;
            thresh_ff <= wsc_pkg::RST_THRESH;
            rdata_ff <= 20'h0_0000;
        end
        else
        begin
            cfg_pair_a_ff <= nxt_cfg_pair_a;
            cfg_pair_b_ff <= nxt_cfg_pair_b;
            ctrl_ff <= nxt_ctrl;
            thresh_ff <= nxt_thresh;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ****************************************************************
    // fixed thresholds
    // ****************************************************************
    logic [7:0] th_low_ff;
    logic [7:0] nxt_th_low;
    logic [8:0] th_high_ff;
    logic [8:0] nxt_th_high;

    always_comb
    begin
        nxt_th_low = thresh_ff[wsc_pkg::TH_LOW_LSB +: 8]; // [R9]
        nxt_th_high = {1'b0, nxt_th_low}
            + {1'b0, thresh_ff[wsc_pkg::TH_OFFS_LSB +: 8]}; // [R9]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            th_low_ff <= 8'h00;
            th_high_ff <= 9'h000;
        end
        else
        begin
            th_low_ff <= nxt_th_low;
            th_high_ff <= nxt_th_high;
        end
    end

    assign fixed_low_threshold = th_low_ff;
    assign fixed_high_threshold = th_high_ff;

    // ****************************************************************
    // channels
    // ****************************************************************
    logic [39:0] cfg_all;
    assign cfg_all = {cfg_pair_b_ff, cfg_pair_a_ff};

    wsc_chan_if chan_if [wsc_pkg::NUM_CH] ();

    genvar gi;
    generate
        for (gi = 0; gi < wsc_pkg::NUM_CH; gi++)
        begin : g_chan
            // even channel in the low half of a pair, odd channel in the high half
            assign chan_if[gi].cfg = cfg_all[gi * wsc_pkg::FLD_W +: wsc_pkg::FLD_W]; // [R7]
            assign chan_if[gi].out_enable = ctrl_ff[wsc_pkg::CTRL_CHEN_LSB + gi];
            assign chan_if[gi].standstill = standstill_detect[gi];
            assign chan_if[gi].sensor_level = sensor_level[gi];
            assign speed_pulse_output[gi] = chan_if[gi].speed_pulse;
            assign pass_through_active[gi] = chan_if[gi].pass_active;
            assign fixed_threshold_active[gi] = chan_if[gi].fixed_thr; // [R4]
            assign three_level_sensor[gi] = chan_if[gi].three_level;
            assign pwm_sensor[gi] = chan_if[gi].pwm_type;
            assign one_edge_per_tooth[gi] = chan_if[gi].one_edge;

            wsc_channel u_chan (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .ch(chan_if[gi].chan)
            );
        end
    endgenerate
endmodule // wsc_top
`default_nettype wire

// [include/wsc_chan_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// one channel: settings in, decoded state out
// ****************************************************************
interface wsc_chan_if;
    logic [9:0] cfg;
    logic out_enable;
    logic standstill;
    logic sensor_level;
    logic speed_pulse;
    logic pass_active;
    logic fixed_thr;
    logic three_level;
    logic pwm_type;
    logic one_edge;

    modport chan (
        input cfg, out_enable, standstill, sensor_level,
        output speed_pulse, pass_active, fixed_thr, three_level, pwm_type, one_edge
    );
    modport ctl (
        output cfg, out_enable, standstill, sensor_level,
        input speed_pulse, pass_active, fixed_thr, three_level, pwm_type, one_edge
    );
endinterface
`default_nettype wire

// [include/wsc_pkg.sv]
// ****************************************************************
// wheel speed channel configuration constants
// ****************************************************************
package wsc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 20;
    localparam int NUM_CH = 4;
    localparam int FLD_W = 10;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CFG_PAIR_A = 8'h03;
    localparam logic [7:0] OFS_CFG_PAIR_B = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h05;
    localparam logic [7:0] OFS_THRESH = 8'h06;

    // ****************************************************************
    // reset values and writable masks
    // ****************************************************************
    localparam logic [19:0] RST_CFG_PAIR = 20'h0_0000;
    localparam logic [19:0] RST_CTRL = 20'h0_0000;
    localparam logic [19:0] RST_THRESH = 20'h0_d033;
    localparam logic [19:0] MASK_CFG_PAIR = 20'hf_effb;
    localparam logic [19:0] MASK_CTRL = 20'h0_022f;
    localparam logic [19:0] MASK_THRESH = 20'h3_fcff;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int PAIR_HI_LSB = 10;
    localparam int PAIR_LO_LSB = 0;
    localparam int FILT_LSB = 6;
    localparam int PASS_BIT = 5;
    localparam int STILL_BIT = 4;
    localparam int FIXTH_BIT = 3;
    localparam int TYPE_LSB = 0;
    localparam int CTRL_CFG_EN_BIT = 5;
    localparam int CTRL_CHEN_LSB = 0;
    localparam int TH_LOW_LSB = 0;
    localparam int TH_OFFS_LSB = 10;

    // ****************************************************************
    // sensor type codes
    // ****************************************************************
    localparam logic [1:0] TYPE_TWO_LEVEL = 2'h0;
    localparam logic [1:0] TYPE_THREE_LEVEL = 2'h1;
    localparam logic [1:0] TYPE_PWM_TWO_EDGE = 2'h2;
    localparam logic [1:0] TYPE_PWM_ONE_EDGE = 2'h3;

    // ****************************************************************
    // filter timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int FILT_BASE_NS = 8000;
    localparam int FILT_STEP_NS = 500;
    localparam int FILT_CNT_W = 9;

    // least time, rounded up to whole cycles
    function automatic logic [8:0] filt_cycles(input logic [3:0] code);
        int t_ns;
        t_ns = FILT_BASE_NS + int'(code) * FILT_STEP_NS;
        return 9'((t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

endpackage

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module tb;
    logic ref_clk, rst_n, reg_wr, reg_rd;
    logic [7:0] reg_addr, fixed_low_threshold;
    logic [19:0] reg_wdata, reg_rdata;
    logic battery_undervoltage_event, ground_loss_event;
    logic [3:0] sensor_level, standstill_detect, speed_pulse_output, pass_through_active;
    logic [3:0] fixed_threshold_active, three_level_sensor, pwm_sensor, one_edge_per_tooth;
    logic [8:0] fixed_high_threshold;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    // written field, read-back field, {pass, fixed, three, pwm, one edge}
    logic [24:0] rows [8] = '{{10'h000, 10'h000, 5'h00}, {10'h001, 10'h001, 5'h04},
        {10'h002, 10'h002, 5'h02}, {10'h003, 10'h003, 5'h03}, {10'h022, 10'h022, 5'h12},
        {10'h021, 10'h021, 5'h04}, {10'h008, 10'h008, 5'h08}, {10'h3fc, 10'h3f8, 5'h08}};
    wsc_top i_wsc_top (
        .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .battery_undervoltage_event, .ground_loss_event, .sensor_level, .standstill_detect,
        .speed_pulse_output, .pass_through_active, .fixed_threshold_active,
        .three_level_sensor, .pwm_sensor, .one_edge_per_tooth, .fixed_low_threshold,
        .fixed_high_threshold
    );
    wsc_sensor i_wsc_sensor (.ref_clk, .sensor_level, .standstill_detect);
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic end_of_test;
        $display("bad_count %0d cmp_count %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [19:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [19:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    task automatic dchk(input int ch, input logic [4:0] e);
        chk(20'({pass_through_active[ch], fixed_threshold_active[ch], three_level_sensor[ch],
            pwm_sensor[ch], one_edge_per_tooth[ch]}), 20'(e));
    endtask
    initial
    begin
        {reg_wr, reg_rd, battery_undervoltage_event, ground_loss_event} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 20'h0_0000;
        rst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(wsc_pkg::OFS_CFG_PAIR_B, 20'h0_0000);
        rd(wsc_pkg::OFS_THRESH, 20'h0_d033);
        chk(20'({fixed_high_threshold, fixed_low_threshold}), 20'h0_6733);
        wr(wsc_pkg::OFS_CFG_PAIR_B, 20'h0_0001);
        rd(wsc_pkg::OFS_CFG_PAIR_B, 20'h0_0000);
        wr(8'h07, 20'hf_ffff);
        rd(8'h07, 20'h0_0000);
        wr(wsc_pkg::OFS_CTRL, 20'h0_002f);
        foreach (rows[i])
        begin
            // different fields in the two halves so a swapped pair shows
            wr(wsc_pkg::OFS_CFG_PAIR_B, {rows[i][24:15], rows[7 - i][24:15]});
            rd(wsc_pkg::OFS_CFG_PAIR_B, {rows[i][14:5], rows[7 - i][14:5]});
            dchk(2, rows[7 - i][4:0]);
            dchk(3, rows[i][4:0]);
        end
        for (int c = 0; c < 16; c += 15)
        begin
            wr(wsc_pkg::OFS_CFG_PAIR_A, 20'(c * 64));
            n = (8000 + c * 500 + 39) / 40;
            i_wsc_sensor.lvl(0, 1'b1);
            wait_cyc(n - 20);
            chk(20'(speed_pulse_output[0]), 20'h0_0000);
            i_wsc_sensor.lvl(0, 1'b0);
            wait_cyc(20);
            chk(20'(speed_pulse_output[0]), 20'h0_0000);
            wait_cyc(n);
            i_wsc_sensor.lvl(0, 1'b1);
            wait_cyc(n - 5);
            chk(20'(speed_pulse_output[0]), 20'h0_0000);
            wait_cyc(15);
            chk(20'(speed_pulse_output[0]), 20'h0_0001);
            i_wsc_sensor.lvl(0, 1'b0);
            wait_cyc(n + 15);
            chk(20'(speed_pulse_output[0]), 20'h0_0000);
        end
        wr(wsc_pkg::OFS_CFG_PAIR_A, 20'h0_0032);
        i_wsc_sensor.lvl(0, 1'b1);
        wait_cyc(5);
        chk(20'(speed_pulse_output[0]), 20'h0_0001);
        i_wsc_sensor.still(0, 1'b1);
        wait_cyc(3);
        chk(20'(speed_pulse_output[0]), 20'h0_0000);
        wr(wsc_pkg::OFS_CFG_PAIR_A, 20'h0_0022);
        wait_cyc(3);
        chk(20'(speed_pulse_output[0]), 20'h0_0001);
        wr(wsc_pkg::OFS_CFG_PAIR_A, 20'h0_0033);
        wait_cyc(3);
        chk(20'(speed_pulse_output[0]), 20'h0_0001);
        i_wsc_sensor.still(0, 1'b0);
        i_wsc_sensor.lvl(0, 1'b0);
        wait_cyc(5);
        chk(20'(speed_pulse_output[0]), 20'h0_0000);
        wr(wsc_pkg::OFS_THRESH, 20'h3_fc80);
        wait_cyc(2);
        chk(20'({fixed_high_threshold, fixed_low_threshold}), 20'h1_7f80);
        rd(wsc_pkg::OFS_THRESH, 20'h3_fc80);
        for (int e = 0; e < 2; e++)
        begin
            wr(wsc_pkg::OFS_CTRL, 20'h0_002f);
            wr(wsc_pkg::OFS_CFG_PAIR_B, 20'h0_0c03);
            @(posedge ref_clk);
            battery_undervoltage_event <= (e == 0);
            ground_loss_event <= (e == 1);
            repeat (6) @(posedge ref_clk);
            {battery_undervoltage_event, ground_loss_event} <= 2'h0;
            wait_cyc(2);
            rd(wsc_pkg::OFS_CFG_PAIR_B, 20'h0_0000);
            rd(wsc_pkg::OFS_CTRL, 20'h0_0000);
            chk(20'(pwm_sensor), 20'h0_0000);
        end
        wr(wsc_pkg::OFS_CTRL, 20'h0_002f);
        wr(wsc_pkg::OFS_CFG_PAIR_B, 20'h0_0003);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(wsc_pkg::OFS_CFG_PAIR_B, 20'h0_0000);
        chk(20'({fixed_high_threshold, fixed_low_threshold}), 20'h0_6733);
        end_of_test();
    end
endmodule // tb
`default_nettype wire

// [tb/wsc_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module wsc_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [19:0] reg_rdata,
    input wire logic battery_undervoltage_event,
    input wire logic [3:0] sensor_level,
    input wire logic [3:0] speed_pulse_output,
    input wire logic [3:0] pass_through_active,
    input wire logic [3:0] fixed_threshold_active,
    input wire logic [3:0] three_level_sensor,
    input wire logic [3:0] pwm_sensor,
    input wire logic [3:0] one_edge_per_tooth,
    input wire logic [7:0] fixed_low_threshold,
    input wire logic [8:0] fixed_high_threshold
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [8:0] hi_cnt_ff;
    logic [8:0] nxt_hi_cnt;
    // run length of a high channel 0 pin, saturating
    always_comb
    begin
        nxt_hi_cnt = hi_cnt_ff;
        if (!sensor_level[0])
            nxt_hi_cnt = 9'h000;
        else if (hi_cnt_ff != 9'h1ff)
            nxt_hi_cnt = hi_cnt_ff + 9'h001;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            hi_cnt_ff <= 9'h000;
        else
            hi_cnt_ff <= nxt_hi_cnt;
    end
    property p_rd_idle; !reg_rd |=> reg_rdata == 20'h0_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unused;
        reg_rd && reg_addr == wsc_pkg::OFS_CFG_PAIR_B |=> !reg_rdata[2] && !reg_rdata[12];
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit read as one");
    property p_unmap; reg_rd && reg_addr > wsc_pkg::OFS_THRESH |=> reg_rdata == 20'h0_0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pass; (pass_through_active & ~pwm_sensor) == 4'h0; endproperty
    a_pass: assert property (p_pass) else $error("pass-through on non pwm type");
    property p_type;
        (three_level_sensor & pwm_sensor) == 4'h0 && (one_edge_per_tooth & ~pwm_sensor) == 4'h0;
    endproperty
    a_type: assert property (p_type) else $error("sensor type decode clash");
    property p_thr;
        fixed_high_threshold >= {1'b0, fixed_low_threshold}
            && fixed_high_threshold <= {1'b0, fixed_low_threshold} + 9'h0ff;
    endproperty
    a_thr: assert property (p_thr) else $error("high threshold out of range");
    property p_clr;
        battery_undervoltage_event [*4] |->
            ##2 (pwm_sensor | fixed_threshold_active | pass_through_active) == 4'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("settings kept over supply event");
    property p_filt;
        $rose(speed_pulse_output[0]) && !pass_through_active[0] && !$past(pass_through_active[0])
            |-> hi_cnt_ff >= 9'h0c8;
    endproperty
    a_filt: assert property (p_filt) else $error("pulse passed filter too early");
    c_rd: cover property (reg_rd && reg_addr == wsc_pkg::OFS_CFG_PAIR_B);
    c_rise: cover property ($rose(speed_pulse_output[0]));
    c_clr: cover property (battery_undervoltage_event [*4]);
endmodule // wsc_assertions
bind wsc_top wsc_assertions i_wsc_assertions (
    .ref_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .battery_undervoltage_event,
    .sensor_level, .speed_pulse_output, .pass_through_active, .fixed_threshold_active,
    .three_level_sensor, .pwm_sensor, .one_edge_per_tooth, .fixed_low_threshold,
    .fixed_high_threshold
);
`default_nettype wire

// [tb/wsc_sensor.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************
// sensor stand-in
// ****************
module wsc_sensor (
    input wire logic ref_clk,
    output logic [3:0] sensor_level,
    output logic [3:0] standstill_detect
);
    initial
    begin
        sensor_level = 4'h0;
        standstill_detect = 4'h0;
    end
    // levels move just after an edge, as a comparator would
    task automatic lvl(input int ch, input logic v);
        @(posedge ref_clk);
        sensor_level[ch] <= v;
    endtask
    task automatic still(input int ch, input logic v);
        @(posedge ref_clk);
        standstill_detect[ch] <= v;
    endtask
endmodule // wsc_sensor
`default_nettype wire
